/* File: rtl/csg_core.sv */
// CPU status register, software stack guard and secure RAM access check
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps

module csg_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // ALU flag update
  input wire logic alu_valid,
  input wire logic alu_byte,
  input wire logic alu_sub,
  input wire logic alu_cin,
  input wire logic [15:0] alu_a,
  input wire logic [15:0] alu_b,
  input wire logic loop_running,
  // Stack requests
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic [15:0] stk_push_data,
  input wire logic pc_push_call,
  input wire logic pc_push_exc,
  input wire logic [22:0] pc_value,
  output logic stk_busy,
  // Stack memory access
  output logic mem_we,
  output logic mem_re,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  // Data RAM access check
  input wire logic ram_acc_valid,
  input wire logic [15:0] ram_acc_addr,
  input wire csg_pkg::csg_seg_type ram_acc_seg,
  output logic ram_acc_deny,
  // Status outputs
  output logic [3:0] cpu_priority_level,
  output logic user_irq_disabled,
  output logic stack_error_trap,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] sr_q;
  logic [15:0] sr_d;
  logic [15:0] core_ctrl_q;
  logic [15:0] int_ctrl_q;
  logic [15:0] sp_q;
  logic [15:0] sp_d;
  logic [15:0] ceil_q;
  logic [15:0] prot_q;
  logic [3:0] evt_q;
  logic [3:0] evt_d;
  logic [3:0] mask_q;

  typedef enum logic {
    CSG_ST_IDLE,
    CSG_ST_PC_HIGH
  } csg_stk_state_type;
  csg_stk_state_type st_q;
  csg_stk_state_type st_d;
  logic [15:0] pc_hi_q;

  // Merge a 32-bit write into a 16-bit register under its byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
  wire rd_fire = s_axi_arvalid && !rvalid_q;
  wire wr_status = wr_fire && awaddr_q == csg_pkg::ADDR_STATUS;
  wire wr_core = wr_fire && awaddr_q == csg_pkg::ADDR_CORE_CTRL;
  wire wr_intc = wr_fire && awaddr_q == csg_pkg::ADDR_INT_CTRL_ONE;
  wire wr_sp = wr_fire && awaddr_q == csg_pkg::ADDR_STACK_PTR;
  wire wr_ceil = wr_fire && awaddr_q == csg_pkg::ADDR_CEILING;
  wire wr_prot = wr_fire && awaddr_q == csg_pkg::ADDR_RAM_PROT;
  wire wr_mask = wr_fire && awaddr_q == csg_pkg::ADDR_EVT_MASK;
  wire wr_mapped = wr_status || wr_core || wr_intc || wr_sp || wr_ceil || wr_prot || wr_mask
                   || (awaddr_q == csg_pkg::ADDR_EVT_STATUS);
  wire rd_evt = rd_fire && s_axi_araddr == csg_pkg::ADDR_EVT_STATUS;

  logic [15:0] rd_val;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      csg_pkg::ADDR_STATUS: rd_val = sr_q;
      csg_pkg::ADDR_CORE_CTRL: rd_val = core_ctrl_q;
      csg_pkg::ADDR_INT_CTRL_ONE: rd_val = int_ctrl_q;
      csg_pkg::ADDR_STACK_PTR: rd_val = sp_q;
      csg_pkg::ADDR_CEILING: rd_val = ceil_q;
      csg_pkg::ADDR_RAM_PROT: rd_val = prot_q;
      csg_pkg::ADDR_EVT_STATUS: rd_val = {12'h000, evt_q};
      csg_pkg::ADDR_EVT_MASK: rd_val = {12'h000, mask_q};
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= csg_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? csg_pkg::RESP_OKAY : csg_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rresp_q <= csg_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_hit ? csg_pkg::RESP_OKAY : csg_pkg::RESP_SLVERR;
      rdata_q <= {16'h0000, rd_val};
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ALU flags
  wire [15:0] alu_bx = alu_sub ? ~alu_b : alu_b;
  wire [4:0] sum_nib = {1'b0, alu_a[3:0]} + {1'b0, alu_bx[3:0]} + {4'h0, alu_cin};
  wire [8:0] sum_byte = {1'b0, alu_a[7:0]} + {1'b0, alu_bx[7:0]} + {8'h00, alu_cin};
  wire [16:0] sum_word = {1'b0, alu_a} + {1'b0, alu_bx} + {16'h0000, alu_cin};
  wire res_msb = alu_byte ? sum_byte[7] : sum_word[15];
  wire a_msb = alu_byte ? alu_a[7] : alu_a[15];
  wire b_msb = alu_byte ? alu_bx[7] : alu_bx[15];
  wire flag_dc = alu_byte ? sum_nib[4] : sum_byte[8];
  wire flag_c = alu_byte ? sum_byte[8] : sum_word[16];
  wire flag_ov = (a_msb == b_msb) && (res_msb != a_msb);
  wire res_zero = alu_byte ? sum_byte[7:0] == 8'h00 : sum_word[15:0] == 16'h0000;
  wire nest_off = int_ctrl_q[csg_pkg::INTC_NEST_OFF];

  always_comb begin
    sr_d = sr_q;
    if (wr_status) begin
      sr_d = merge16(sr_q, wdata_q, wstrb_q) & csg_pkg::SR_WRITE_MASK;
      if (nest_off) begin
        sr_d[csg_pkg::SR_IPL_HI:csg_pkg::SR_IPL_LO] =
          sr_q[csg_pkg::SR_IPL_HI:csg_pkg::SR_IPL_LO];
      end
    end
    if (alu_valid) begin
      sr_d[csg_pkg::SR_DC] = flag_dc;
      sr_d[csg_pkg::SR_N] = res_msb;
      sr_d[csg_pkg::SR_OV] = flag_ov;
      sr_d[csg_pkg::SR_Z] = res_zero;
      sr_d[csg_pkg::SR_C] = flag_c;
    end
    sr_d[csg_pkg::SR_RA] = loop_running;
  end

  // Priority level: top bit from core control forms levels 8..15
  assign cpu_priority_level = {core_ctrl_q[csg_pkg::CORE_IPL_TOP],
                               sr_q[csg_pkg::SR_IPL_HI:csg_pkg::SR_IPL_LO]};
  assign user_irq_disabled = core_ctrl_q[csg_pkg::CORE_IPL_TOP]
    || sr_q[csg_pkg::SR_IPL_HI:csg_pkg::SR_IPL_LO] == csg_pkg::IPL_LEVEL_MAX;

  ////////////////////////////////////////////////////////////////////////////
  // Software stack
  wire start_pc = st_q == CSG_ST_IDLE && (pc_push_call || pc_push_exc);
  wire do_push = (st_q == CSG_ST_PC_HIGH) || start_pc || (st_q == CSG_ST_IDLE && stk_push);
  wire do_pop = st_q == CSG_ST_IDLE && !stk_push && !start_pc && stk_pop;
  wire [15:0] pop_ea = sp_q - csg_pkg::STACK_STEP;
  wire [15:0] stk_ea = do_pop ? pop_ea : sp_q;
  wire ceil_trap = do_push && sp_q > ceil_q;
  wire floor_trap = (do_push || do_pop) && stk_ea < csg_pkg::STACK_FLOOR;
  wire [7:0] pc_prefix = pc_push_exc ? sr_q[7:0] : 8'h00;
  wire [15:0] push_word = st_q == CSG_ST_PC_HIGH ? pc_hi_q :
                          start_pc ? {pc_value[15:1], 1'b0} : stk_push_data;

  assign stk_busy = st_q != CSG_ST_IDLE;
  always_comb begin
    st_d = st_q;
    sp_d = sp_q;
    unique case (st_q)
      CSG_ST_IDLE: begin
        if (start_pc) begin
          st_d = CSG_ST_PC_HIGH;
        end
      end
      CSG_ST_PC_HIGH: st_d = CSG_ST_IDLE;
    endcase
    if (do_push) begin
      sp_d = sp_q + csg_pkg::STACK_STEP;
    end else if (do_pop) begin
      sp_d = pop_ea;
    end else if (wr_sp) begin
      sp_d = merge16(sp_q, wdata_q, wstrb_q);
    end
    sp_d[0] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= CSG_ST_IDLE;
      sp_q <= csg_pkg::SP_RESET;
      pc_hi_q <= 16'h0000;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
    end else begin
      st_q <= st_d;
      sp_q <= sp_d;
      if (start_pc) begin
        pc_hi_q <= {pc_prefix, 1'b0, pc_value[22:16]};
      end
      mem_we <= do_push;
      mem_re <= do_pop;
      mem_addr <= stk_ea;
      mem_wdata <= push_word;
    end
  end

  // Ceiling has no reset by design; bit 0 reads zero once the ceiling has been written
  always_ff @(posedge clk) begin
    if (wr_ceil) begin
      ceil_q <= merge16(ceil_q, wdata_q, wstrb_q) & 16'hfffe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Secure RAM windows
  wire in_boot = ram_acc_addr >= csg_pkg::BOOT_RAM_LO && ram_acc_addr <= csg_pkg::BOOT_RAM_HI;
  wire in_sec = ram_acc_addr >= csg_pkg::SEC_RAM_LO && ram_acc_addr <= csg_pkg::SEC_RAM_HI;
  wire boot_bad = prot_q[csg_pkg::PROT_BOOT_EN] && in_boot
                  && ram_acc_seg != csg_pkg::CSG_SEG_BOOT;
  wire sec_bad = prot_q[csg_pkg::PROT_SEC_EN] && in_sec
                 && ram_acc_seg != csg_pkg::CSG_SEG_SECURE;
  wire ram_bad = ram_acc_valid && (boot_bad || sec_bad);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, events and interrupt
  // Set beats the read clear in the same cycle
  wire [2:0] evt_set = {ram_bad, floor_trap, ceil_trap};
  always_comb begin
    evt_d = rd_evt ? 4'h0 : evt_q;
    evt_d = evt_d | {1'b0, evt_set};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sr_q <= csg_pkg::SR_RESET;
      core_ctrl_q <= 16'h0000;
      int_ctrl_q <= 16'h0000;
      prot_q <= 16'h0000;
      evt_q <= 4'h0;
      mask_q <= 4'h0;
      ram_acc_deny <= 1'b0;
      stack_error_trap <= 1'b0;
    end else begin
      sr_q <= sr_d;
      if (wr_core) begin
        core_ctrl_q <= merge16(core_ctrl_q, wdata_q, wstrb_q) & 16'h0008;
      end
      if (wr_intc) begin
        int_ctrl_q <= merge16(int_ctrl_q, wdata_q, wstrb_q) & 16'h8000;
      end
      if (wr_prot) begin
        prot_q <= merge16(prot_q, wdata_q, wstrb_q) & 16'h0003;
      end
      if (wr_mask && wstrb_q[0]) begin
        mask_q <= {1'b0, wdata_q[2:0]};
      end
      evt_q <= evt_d;
      ram_acc_deny <= ram_bad;
      stack_error_trap <= ceil_trap || floor_trap;
    end
  end

  assign irq = |(evt_q & mask_q);

endmodule // csg_core

/* File: include/csg_pkg.sv */
// Constants for the CPU status and stack guard block
package csg_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CORE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_INT_CTRL_ONE = 8'h08;
  localparam logic [7:0] ADDR_STACK_PTR = 8'h0c;
  localparam logic [7:0] ADDR_CEILING = 8'h10;
  localparam logic [7:0] ADDR_RAM_PROT = 8'h14;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h18;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h1c;

  // Status register fields
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_OV = 2;
  localparam int SR_N = 3;
  localparam int SR_RA = 4;
  localparam int SR_IPL_LO = 5;
  localparam int SR_IPL_HI = 7;
  localparam int SR_DC = 8;
  localparam logic [15:0] SR_WRITE_MASK = 16'h01ef;

  // Control fields
  localparam int CORE_IPL_TOP = 3;
  localparam int INTC_NEST_OFF = 15;
  localparam int PROT_BOOT_EN = 0;
  localparam int PROT_SEC_EN = 1;

  // Event bits
  localparam int EVT_CEIL = 0;
  localparam int EVT_FLOOR = 1;
  localparam int EVT_RAM = 2;
  localparam int EVT_W = 3;

  // Reset values and the highest IPL field value
  localparam logic [15:0] SR_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [2:0] IPL_LEVEL_MAX = 3'h7;

  // Stack floor, stack step and protected RAM windows
  localparam logic [15:0] STACK_FLOOR = 16'h0800;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] BOOT_RAM_LO = 16'h0800;
  localparam logic [15:0] BOOT_RAM_HI = 16'h08ff;
  localparam logic [15:0] SEC_RAM_LO = 16'h0900;
  localparam logic [15:0] SEC_RAM_HI = 16'h09ff;

  // Code segment executing the access
  typedef enum logic [1:0] {
    CSG_SEG_GENERAL,
    CSG_SEG_BOOT,
    CSG_SEG_SECURE
  } csg_seg_type;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: bench/csg_core_props.sv */
// Concurrent checks on the stack guard and status block ports
`timescale 1ns/100ps
module csg_core_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Stack side
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic pc_push_call,
  input wire logic pc_push_exc,
  input wire logic stk_busy,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic stack_error_trap,
  // RAM check and priority
  input wire logic ram_acc_valid,
  input wire logic [15:0] ram_acc_addr,
  input wire csg_pkg::csg_seg_type ram_acc_seg,
  input wire logic ram_acc_deny,
  input wire logic [3:0] cpu_priority_level,
  input wire logic user_irq_disabled
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  wire logic pc_any = pc_push_call || pc_push_exc;
  wire logic push_go = stk_push && !stk_busy && !pc_any;
  wire logic pop_go = stk_pop && !stk_busy && !stk_push && !pc_any;
  wire logic in_boot = ram_acc_addr >= csg_pkg::BOOT_RAM_LO
    && ram_acc_addr <= csg_pkg::BOOT_RAM_HI;
  wire logic in_sec = ram_acc_addr >= csg_pkg::SEC_RAM_LO && ram_acc_addr <= csg_pkg::SEC_RAM_HI;
  wire logic own_seg = !(in_boot && ram_acc_seg != csg_pkg::CSG_SEG_BOOT)
    && !(in_sec && ram_acc_seg != csg_pkg::CSG_SEG_SECURE);
  // Second word lands one word above the first
  sequence pc_words;
    mem_we && stk_busy ##1 mem_we && !stk_busy && mem_addr == $past(mem_addr) + 16'h0002;
  endsequence
  ////////////////////////////////////////////////////////////
  a_push_write: assert property (push_go |=> mem_we && !mem_re)
    else $error("push gave no write");
  a_pop_read: assert property (pop_go |=> mem_re && !mem_we)
    else $error("pop gave no read");
  a_addr_aligned: assert property ((mem_we || mem_re) |-> !mem_addr[0])
    else $error("odd stack address");
  a_pc_two_words: assert property (!stk_busy && pc_any |=> pc_words)
    else $error("bad pc push words");
  a_call_msb_clear: assert property (!stk_busy && pc_push_call && !pc_push_exc
    |=> ##1 mem_wdata[15:7] == 9'h000)
    else $error("call high word not clear");
  a_floor_trap: assert property ((mem_we || mem_re) && !$past(stk_busy)
    && mem_addr < csg_pkg::STACK_FLOOR |-> stack_error_trap)
    else $error("no trap below floor");
  a_trap_cause: assert property (stack_error_trap |-> mem_we || mem_re)
    else $error("trap without stack access");
  a_prio_disable: assert property (user_irq_disabled
    == (cpu_priority_level[3] || cpu_priority_level[2:0] == 3'h7))
    else $error("user interrupt disable wrong");
  a_ram_own_seg: assert property (ram_acc_valid && own_seg |=> !ram_acc_deny)
    else $error("allowed access denied");
endmodule // csg_core_props

/* File: bench/csg_core_tb.sv */
// Self-checking bench for the CPU status and stack guard block
`timescale 1ns/100ps
module csg_core_tb;
  logic clk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
  logic alu_valid = 1'b0, alu_byte = 1'b0, alu_sub = 1'b0, alu_cin = 1'b0, loop_running = 1'b0;
  logic [15:0] alu_a = 16'h0, alu_b = 16'h0, stk_push_data = 16'h0, ram_acc_addr = 16'h0;
  logic stk_push = 1'b0, stk_pop = 1'b0, pc_push_call = 1'b0, pc_push_exc = 1'b0;
  logic ram_acc_valid = 1'b0;
  logic [22:0] pc_value = 23'h0;
  csg_pkg::csg_seg_type ram_acc_seg = csg_pkg::CSG_SEG_GENERAL;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, stk_busy;
  logic mem_we, mem_re, ram_acc_deny, user_irq_disabled, stack_error_trap, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic [15:0] mem_addr, mem_wdata, sp_m, rd_d, a, b, e;
  logic [3:0] cpu_priority_level;
  int bad_count = 0, total_checks = 0, cycles = 0, seed = 65;
  // Responses are always accepted at once
  csg_core u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(1'b1), .alu_valid(alu_valid), .alu_byte(alu_byte), .alu_sub(alu_sub),
    .alu_cin(alu_cin), .alu_a(alu_a), .alu_b(alu_b), .loop_running(loop_running),
    .stk_push(stk_push), .stk_pop(stk_pop), .stk_push_data(stk_push_data),
    .pc_push_call(pc_push_call), .pc_push_exc(pc_push_exc), .pc_value(pc_value),
    .stk_busy(stk_busy), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .ram_acc_valid(ram_acc_valid), .ram_acc_addr(ram_acc_addr),
    .ram_acc_seg(ram_acc_seg), .ram_acc_deny(ram_acc_deny),
    .cpu_priority_level(cpu_priority_level), .user_irq_disabled(user_irq_disabled),
    .stack_error_trap(stack_error_trap), .irq(irq));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] flags(input logic byt, sub, cin, input logic [15:0] x, y);
    logic [15:0] yy;
    logic [16:0] s, c;
    int m;
    yy = sub ? ~y : y;
    s = {1'b0, x} + {1'b0, yy} + {16'h0, cin};
    // Carry into each bit, recovered from the sum
    c = s ^ {1'b0, x} ^ {1'b0, yy};
    m = byt ? 8 : 16;
    flags = 16'h0000;
    flags[8] = c[m / 2];
    flags[0] = c[m];
    flags[3] = s[m - 1];
    flags[2] = c[m] ^ c[m - 1];
    flags[1] = byt ? (s[7:0] == 8'h00) : (s[15:0] == 16'h0000);
    return flags;
  endfunction
  task automatic axi_wr(input logic [7:0] ad, input logic [15:0] d);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rd_r = s_axi_bresp;
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [7:0] ad);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata[15:0];
    rd_r = s_axi_rresp;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [15:0] m, input logic [15:0] e);
    axi_rd(ad);
    chk(rd_d & m, e);
  endtask
  task automatic stk(input logic pop, input logic [15:0] d, input logic trap);
    stk_push <= !pop;
    stk_pop <= pop;
    stk_push_data <= d;
    @(posedge clk);
    stk_push <= 1'b0;
    stk_pop <= 1'b0;
    if (pop) sp_m = sp_m - 16'h0002;
    @(posedge clk);
    chk({mem_we, mem_re, stack_error_trap, 13'h0}, {!pop, pop, trap, 13'h0});
    chk(mem_addr, sp_m);
    if (!pop) chk(mem_wdata, d);
    if (!pop) sp_m = sp_m + 16'h0002;
  endtask
  task automatic pcp(input logic exc, input logic [22:0] pc, input logic [7:0] pre);
    pc_push_call <= !exc;
    pc_push_exc <= exc;
    pc_value <= pc;
    @(posedge clk);
    pc_push_call <= 1'b0;
    pc_push_exc <= 1'b0;
    @(posedge clk);
    chk(mem_wdata, {pc[15:1], 1'b0});
    chk(mem_addr, sp_m);
    @(posedge clk);
    chk(mem_wdata, {pre, 1'b0, pc[22:16]});
    chk(mem_addr, sp_m + 16'h0002);
    sp_m = sp_m + 16'h0004;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i != 4) rdc(8'(i * 4), 16'hffff, (i == 3) ? csg_pkg::SP_RESET : 16'h0000);
    end
    axi_rd(8'h20);
    chk({rd_d[15:2], rd_r}, {14'h0, csg_pkg::RESP_SLVERR});
    axi_wr(8'h24, 16'hffff);
    chk({14'h0, rd_r}, {14'h0, csg_pkg::RESP_SLVERR});
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      a = (i == 0) ? 16'h0000 : (i == 1) ? 16'h7fff : r[15:0];
      b = (i < 2) ? 16'(i) : r[31:16];
      alu_a <= a;
      alu_b <= b;
      alu_byte <= r[4] && i > 1;
      alu_sub <= r[5];
      alu_cin <= r[6];
      alu_valid <= 1'b1;
      @(posedge clk);
      alu_valid <= 1'b0;
      e = flags(r[4] && i > 1, r[5], r[6], a, b);
      rdc(csg_pkg::ADDR_STATUS, 16'h010f, e);
    end
    axi_wr(csg_pkg::ADDR_STATUS, 16'h00e0);
    chk({11'h0, user_irq_disabled, cpu_priority_level}, 16'h0017);
    axi_wr(csg_pkg::ADDR_CORE_CTRL, 16'h0008);
    axi_wr(csg_pkg::ADDR_STATUS, 16'h0040);
    chk({11'h0, user_irq_disabled, cpu_priority_level}, 16'h001a);
    axi_wr(csg_pkg::ADDR_CORE_CTRL, 16'h0000);
    chk({11'h0, user_irq_disabled, cpu_priority_level}, 16'h0002);
    axi_wr(csg_pkg::ADDR_INT_CTRL_ONE, 16'h8000);
    axi_wr(csg_pkg::ADDR_STATUS, 16'h00ad);
    rdc(csg_pkg::ADDR_STATUS, 16'h00ef, 16'h004d);
    loop_running <= 1'b1;
    @(posedge clk);
    rdc(csg_pkg::ADDR_STATUS, 16'h0010, 16'h0010);
    loop_running <= 1'b0;
    @(posedge clk);
    rdc(csg_pkg::ADDR_STATUS, 16'h0010, 16'h0000);
    sp_m = csg_pkg::SP_RESET;
    axi_wr(csg_pkg::ADDR_CEILING, 16'h0805);
    rdc(csg_pkg::ADDR_CEILING, 16'hffff, 16'h0804);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      stk(1'b0, r[15:0], i == 3);
    end
    chk(16'(irq), 16'h0000);
    axi_wr(csg_pkg::ADDR_EVT_MASK, 16'h0007);
    chk(16'(irq), 16'h0001);
    rdc(csg_pkg::ADDR_EVT_STATUS, 16'hffff, 16'h0001);
    chk(16'(irq), 16'h0000);
    stk(1'b1, 16'h0000, 1'b0);
    axi_wr(csg_pkg::ADDR_CEILING, 16'h0ffe);
    r = $random(seed);
    pcp(1'b0, r[22:0] | 23'h400000, 8'h00);
    pcp(1'b1, r[22:0], 8'h4d);
    axi_wr(csg_pkg::ADDR_STACK_PTR, 16'h0801);
    sp_m = csg_pkg::STACK_FLOOR;
    stk(1'b1, 16'h0000, 1'b1);
    rdc(csg_pkg::ADDR_EVT_STATUS, 16'hffff, 16'h0002);
    rdc(csg_pkg::ADDR_STACK_PTR, 16'hffff, 16'h07fe);
    axi_wr(csg_pkg::ADDR_RAM_PROT, 16'h0003);
    for (int i = 0; i < 18; i++) begin
      if (i == 9) axi_wr(csg_pkg::ADDR_RAM_PROT, 16'h0000);
      r = $random(seed);
      ram_acc_seg <= csg_pkg::csg_seg_type'(i % 3);
      ram_acc_addr <= 16'h0800 + 16'((i % 9) / 3) * 16'h0100 + {8'h00, r[7:0]};
      ram_acc_valid <= 1'b1;
      @(posedge clk);
      ram_acc_valid <= 1'b0;
      @(posedge clk);
      chk(16'(ram_acc_deny), 16'(i < 9 && (i % 9) / 3 < 2 && (i % 9) / 3 + 1 != i % 3));
    end
    rdc(csg_pkg::ADDR_EVT_STATUS, 16'h0004, 16'h0004);
    report_and_stop();
  end
endmodule // csg_core_tb
bind csg_core csg_core_props u_props (.clk(clk), .rst(rst), .stk_push(stk_push),
  .stk_pop(stk_pop), .pc_push_call(pc_push_call), .pc_push_exc(pc_push_exc),
  .stk_busy(stk_busy), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .stack_error_trap(stack_error_trap), .ram_acc_valid(ram_acc_valid),
  .ram_acc_addr(ram_acc_addr), .ram_acc_seg(ram_acc_seg), .ram_acc_deny(ram_acc_deny),
  .cpu_priority_level(cpu_priority_level), .user_irq_disabled(user_irq_disabled));
